// ### rtl/lpcs_ctrl.v
// Clock-stop and wake controller that sits beside a static processor core.
// Overview of operation
// - Match on supervisor-data write to trigger address.
// - Trigger address compared on all bits.
// - Count bus cycles, stop clock after operand.
// - Eight-bit bus waits one more cycle.
// - Clock gating never produces runt pulses.
// - Finish bus arbitration during status-word fetch.
// - Watch interrupt level while clock stopped.
// - Restart clock, wait stable, then wake.
// - Never wake while clock unstable.
// - Drop grant-ack and request before resuming.
// - Trap routine writes, halts, then returns.
`include "lpcs_defs.vh"
`default_nettype none
module lpcs_ctrl #(
  parameter [31:0] LP_ADDR    = `LPCS_LP_ADDR_DFLT,
  parameter [2:0]  WAKE_LEVEL = `LPCS_WAKE_LVL_DFLT,
  parameter        USE_ARB    = 1,
  parameter        STABLE_CYC = `LPCS_STABLE_CYC
) (
  input  wire        CLK,
  input  wire        SRST,
  input  wire [31:0] ADDR,
  input  wire        READ_NOT_WRITE,
  input  wire [2:0]  FUNCTION_CODE,
  input  wire        BUS_CYCLE_END,
  input  wire        BYTE_BUS,
  input  wire [2:0]  INTERRUPT_LEVEL_N,
  input  wire        BUS_GRANT,
  output reg         CORE_CLK_EN,
  output reg         SYS_CLK_RUN,
  output reg         WAKE_REQUEST_N,
  output reg         BUS_REQUEST_N,
  output reg         BUS_GRANT_ACK_N,
  output reg         LOW_POWER
);
  localparam [1:0]  ST_RUN     = `LPCS_ST_RUN;
  localparam [1:0]  ST_COUNT   = `LPCS_ST_COUNT;
  localparam [1:0]  ST_STOPPED = `LPCS_ST_STOPPED;
  localparam [1:0]  ST_WAKE    = `LPCS_ST_WAKE;
  localparam [1:0]  CNT_ONE    = 2'h1;
  localparam [1:0]  CNT_ZERO   = 2'h0;
  localparam [15:0] STAB_LAST  = STABLE_CYC[15:0];

  reg  [31:0] addr_s1_r;
  reg  [31:0] addr_s2_r;
  reg         rnw_s1_r;
  reg         rnw_s2_r;
  reg  [2:0]  fc_s1_r;
  reg  [2:0]  fc_s2_r;
  reg         end_s1_r;
  reg         end_s2_r;
  reg         end_d_r;
  reg         byte_s1_r;
  reg         byte_s2_r;
  reg  [2:0]  ipl_s1_r;
  reg  [2:0]  ipl_s2_r;
  reg         bg_s1_r;
  reg         bg_s2_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [1:0]  cnt_r;
  reg  [1:0]  cnt_nxt;
  reg  [15:0] stab_r;
  reg  [15:0] stab_nxt;
  wire        cyc_done;
  wire        hit;
  wire [1:0]  stop_cnt;
  wire [1:0]  cnt_inc;
  wire        wake_seen;
  wire        stab_done;

  // True in the states in which the core clock is allowed to run.
  function core_on;
    input [1:0] st;
    begin
      core_on = (st == ST_RUN) | (st == ST_COUNT);
    end
  endfunction

  // True in the states in which the halt sequence owns the bus.
  function in_halt;
    input [1:0] st;
    begin
      in_halt = (st == ST_COUNT) | (st == ST_STOPPED);
    end
  endfunction

  // True once the halt sequence has counted at least one cycle end.
  function wants_bus;
    input [1:0] st;
    input [1:0] cnt;
    begin
      wants_bus = ((st == ST_COUNT) & (cnt != CNT_ZERO)) | (st == ST_STOPPED);
    end
  endfunction

  assign cyc_done  = end_s2_r & ~end_d_r;
  assign hit       = (addr_s2_r == LP_ADDR) & ~rnw_s2_r &
                     (fc_s2_r == `LPCS_FC_SUPV_DATA);
  assign stop_cnt  = byte_s2_r ? `LPCS_CNT_STOP_8 : `LPCS_CNT_STOP_16;
  assign cnt_inc   = cnt_r + CNT_ONE;
  assign wake_seen = (~ipl_s2_r == WAKE_LEVEL);
  assign stab_done = (stab_r == STAB_LAST);

  // Every input pin except CLK and SRST passes two flops; the first stage feeds only the second.
  always @(posedge CLK) begin
    addr_s1_r <= ADDR;
    addr_s2_r <= addr_s1_r;
  end

  // The core holds address and direction for the whole write, so a per-bit
  // synchroniser is enough; the match is only trusted while they stand.
  always @(posedge CLK) begin
    rnw_s1_r <= READ_NOT_WRITE;
    rnw_s2_r <= rnw_s1_r;
  end

  always @(posedge CLK) begin
    fc_s1_r <= FUNCTION_CODE;
    fc_s2_r <= fc_s1_r;
  end

  // The third stage only remembers the last value to find the rising edge.
  always @(posedge CLK) begin
    end_s1_r <= BUS_CYCLE_END;
    end_s2_r <= end_s1_r;
    end_d_r  <= end_s2_r;
  end

  always @(posedge CLK) begin
    byte_s1_r <= BYTE_BUS;
    byte_s2_r <= byte_s1_r;
  end

  // The interrupt level arrives from another domain and releases the gate.
  always @(posedge CLK) begin
    ipl_s1_r <= INTERRUPT_LEVEL_N;
    ipl_s2_r <= ipl_s1_r;
  end

  always @(posedge CLK) begin
    bg_s1_r <= BUS_GRANT;
    bg_s2_r <= bg_s1_r;
  end

  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    stab_nxt  = stab_r;
    case (state_r)
      ST_RUN: begin
        cnt_nxt = CNT_ZERO;
        if (hit) begin
          state_nxt = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (cyc_done) begin
          cnt_nxt = cnt_inc;
          if (cnt_inc == stop_cnt) begin
            state_nxt = ST_STOPPED;
          end
        end
      end
      ST_STOPPED: begin
        stab_nxt = 16'h0;
        if (wake_seen) begin
          state_nxt = ST_WAKE;
        end
      end
      default: begin
        // The oscillator runs again here; the core waits for the full count.
        if (stab_done) begin
          state_nxt = ST_RUN;
          cnt_nxt   = CNT_ZERO;
        end else begin
          stab_nxt = stab_r + 16'h1;
        end
      end
    endcase
  end

  always @(posedge CLK) begin
    if (SRST) begin
      state_r <= ST_RUN;
      cnt_r   <= CNT_ZERO;
      stab_r  <= 16'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      stab_r  <= stab_nxt;
    end
  end

  // The external gate latches this enable on the falling edge of the clock,
  // so the core only ever sees whole periods and never a runt.
  always @(posedge CLK) begin
    if (SRST) begin
      CORE_CLK_EN <= 1'b1;
    end else begin
      CORE_CLK_EN <= core_on(state_nxt);
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      SYS_CLK_RUN <= 1'b1;
    end else begin
      SYS_CLK_RUN <= (state_nxt != ST_STOPPED);
    end
  end

  // Wake is a single low cycle after the stable wait, on the same edge that
  // opens the core clock gate again.
  always @(posedge CLK) begin
    if (SRST) begin
      WAKE_REQUEST_N <= 1'b1;
    end else begin
      WAKE_REQUEST_N <= ~((state_r == ST_WAKE) & stab_done);
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      LOW_POWER <= 1'b0;
    end else begin
      LOW_POWER <= (state_nxt == ST_STOPPED);
    end
  end

  // Without an arbiter the bus lines stay negated for good.
  always @(posedge CLK) begin
    if (SRST) begin
      BUS_REQUEST_N <= 1'b1;
    end else if (USE_ARB != 0) begin
      BUS_REQUEST_N <= ~wants_bus(state_nxt, cnt_nxt);
    end else begin
      BUS_REQUEST_N <= 1'b1;
    end
  end

  // Acknowledge is kept once taken, and dropped as soon as the wake begins.
  always @(posedge CLK) begin
    if (SRST) begin
      BUS_GRANT_ACK_N <= 1'b1;
    end else if (USE_ARB != 0) begin
      BUS_GRANT_ACK_N <= ~((bg_s2_r | ~BUS_GRANT_ACK_N) & in_halt(state_nxt));
    end else begin
      BUS_GRANT_ACK_N <= 1'b1;
    end
  end
endmodule // lpcs_ctrl
`default_nettype wire

// ### rtl/lpcs_defs.vh
// Constants for the low-power clock-stop and wake controller.
`ifndef LPCS_DEFS_VH
`define LPCS_DEFS_VH
`define LPCS_FC_SUPV_DATA   3'h5
`define LPCS_LP_ADDR_DFLT   32'hffff_fff0
`define LPCS_CNT_W          2
`define LPCS_CNT_STOP_16    2'h2
`define LPCS_CNT_STOP_8     2'h3
`define LPCS_STABLE_NS      1000
`define LPCS_CLK_NS         10
`define LPCS_STABLE_CYC     ((`LPCS_STABLE_NS + `LPCS_CLK_NS - 1) / `LPCS_CLK_NS)
`define LPCS_WAKE_LVL_DFLT  3'h7
`define LPCS_ST_RUN         2'h0
`define LPCS_ST_COUNT       2'h1
`define LPCS_ST_STOPPED     2'h2
`define LPCS_ST_WAKE        2'h3
`endif

// ### dv/lpcs_chk_asserts.sv
// Checker for the clock-stop controller outputs.
`default_nettype none
module lpcs_chk #(parameter int STABLE_CYC = 4) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CORE_CLK_EN,
  input wire logic SYS_CLK_RUN,
  input wire logic WAKE_REQUEST_N,
  input wire logic BUS_REQUEST_N,
  input wire logic LOW_POWER,
  input wire logic [2:0] INTERRUPT_LEVEL_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_pulse; !WAKE_REQUEST_N ##1 WAKE_REQUEST_N; endsequence
  sequence s_quiet; (LOW_POWER && INTERRUPT_LEVEL_N != 3'h0) [*3]; endsequence
  AST_CORE: assert property (LOW_POWER |-> !CORE_CLK_EN) else $error("core on");
  AST_SYS: assert property ($rose(LOW_POWER) |-> !SYS_CLK_RUN) else $error("sys on");
  AST_HOLD: assert property (s_quiet |-> !SYS_CLK_RUN) else $error("woke early");
  AST_WAIT: assert property ($rose(SYS_CLK_RUN) |-> ##[1:20] !WAKE_REQUEST_N) else $error("no wake");
  AST_ONE: assert property (!WAKE_REQUEST_N |-> s_pulse) else $error("long wake");
  AST_EN: assert property (!WAKE_REQUEST_N |-> CORE_CLK_EN) else $error("core off");
  AST_STAB: assert property (!WAKE_REQUEST_N |-> $past(SYS_CLK_RUN, STABLE_CYC)) else $error("unstable");
  AST_ARB: assert property (!WAKE_REQUEST_N |=> BUS_REQUEST_N) else $error("bus held");
endmodule // lpcs_chk
bind lpcs_ctrl lpcs_chk #(.STABLE_CYC(STABLE_CYC)) u_chk (.*);
`default_nettype wire

// ### dv/lpcs_core.sv
// Core model: bus cycle ends while clocked, and bus grant.
`default_nettype none
module lpcs_core (
  input wire logic clk,
  input wire logic run,
  input wire logic req_n,
  output var logic cyc = 1'b0,
  output var logic gnt = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] n_r = 2'h0;
  always @(posedge clk) begin
    gnt <= ~req_n;
    if (run) n_r <= n_r + 2'h1;
    if (run && n_r == 2'h3) cyc <= ~cyc;
  end
endmodule // lpcs_core
`default_nettype wire

// ### dv/tb.sv
// Bench for the clock-stop controller.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, SRST = 1, RNW = 1, BB = 0, CE, SR, WR, BR, BA, LP, CY, GR;
  logic [31:0] AD = 32'h0;
  logic [2:0] FC = 3'h0, IL = 3'h7;
  int num_errors = 0, check_count = 0;
  lpcs_ctrl #(.STABLE_CYC(4)) dut (.CLK(CLK), .SRST(SRST), .ADDR(AD), .READ_NOT_WRITE(RNW),
    .FUNCTION_CODE(FC), .BUS_CYCLE_END(CY), .BYTE_BUS(BB), .INTERRUPT_LEVEL_N(IL),
    .BUS_GRANT(GR), .CORE_CLK_EN(CE), .SYS_CLK_RUN(SR), .WAKE_REQUEST_N(WR),
    .BUS_REQUEST_N(BR), .BUS_GRANT_ACK_N(BA), .LOW_POWER(LP));
  lpcs_core core (.clk(CLK), .run(CE), .req_n(BR), .cyc(CY), .gnt(GR));
  initial forever #5 CLK = ~CLK;
  task chk(input logic g, e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %0t %h %h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Write just after a cycle end so only the next end can be counted.
  task run(input logic b, input logic [2:0] f, input logic [31:0] a, input logic s);
    int i;
    @(posedge CY);
    @(posedge CLK);
    {BB, AD, FC, RNW} <= {b, a, f, 1'b0};
    repeat (6) @(posedge CLK);
    RNW <= 1'b1;
    // The write's own end counts first; the opcode fetch's end is the second.
    @(posedge CY);
    @(posedge CY);
    repeat (6) @(posedge CLK) #1;
    chk(LP, s & ~b);
    repeat (60) @(posedge CLK) #1;
    chk(LP, s);
    if (s) begin
      chk(BA, 1'b0);
      @(posedge CLK) IL <= 3'h0;
      for (i = 0; i < 40 && WR !== 1'b0; i++) @(posedge CLK) #1;
      chk(CE & SR & ~WR, 1'b1);
      @(posedge CLK) IL <= 3'h7;
      repeat (3) @(posedge CLK) #1;
      chk(BA & BR, 1'b1);
    end
  endtask
  task s_fc; run(1'b0, 3'h1, 32'hffff_fff0, 1'b0); endtask
  task s_adr; run(1'b0, 3'h5, 32'h7fff_fff0, 1'b0); endtask
  task s_w16; run(1'b0, 3'h5, 32'hffff_fff0, 1'b1); endtask
  task s_w8; run(1'b1, 3'h5, 32'hffff_fff0, 1'b1); endtask
  initial begin
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    s_fc();
    s_adr();
    s_w16();
    s_w8();
    finish_test();
  end
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
